// ===== sim/sat_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sat_monitor
  import sat_pkg::*;
#(
  parameter int ENTRIES = SAT_ENTRIES
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Register port
  input wire logic [11:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // Lookup
  input wire sat_lookup_req_t dreq_in,
  input wire logic use_stg_in,
  input wire sat_lookup_res_t hres_in,
  input wire logic hres_static_in,
  input wire sat_lookup_res_t dres_out,
  input wire logic src_valid_in,
  input wire logic [47:0] src_mac_in,
  input wire logic src_drop_out,
  // Status
  input wire logic busy_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  ////////////////////////////////////////////////////////////
  // Idle start only; a start while busy is refused
  sequence s_go;
    reg_wr_in && reg_addr_in == SAT_OFS_CTRL && reg_wdata_in[SAT_CTRL_GO_BIT] && !busy_out;
  endsequence
  sequence s_rd(logic [11:0] a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  a_go_sets_busy: assert property (s_go |-> ##[1:2] busy_out)
    else $error("busy not raised by start");
  a_busy_holds: assert property ($rose(busy_out) |=> busy_out)
    else $error("busy dropped too early");
  a_busy_ends: assert property ($rose(busy_out) |-> ##[1:5] !busy_out)
    else $error("busy never cleared");
  a_w1_res_zero: assert property (s_rd(SAT_OFS_WORD1) |=> (reg_rdata_out & 32'h03ff_fff8) == 0)
    else $error("word1 reserved bits set");
  a_w2_res_zero: assert property (s_rd(SAT_OFS_WORD2) |=> (reg_rdata_out & 32'h3fff_ff90) == 0)
    else $error("word2 reserved bits set");
  a_w3_res_zero: assert property (s_rd(SAT_OFS_WORD3) |=> reg_rdata_out[31:23] == 9'h0)
    else $error("word3 reserved bits set");
  a_hash_static_wins: assert property (dreq_in.valid && hres_in.hit && hres_static_in |=>
    dres_out.hit && dres_out.ports == $past(hres_in.ports))
    else $error("static hashed hit lost");
  a_no_req_idle: assert property (!dreq_in.valid && !hres_in.hit |=> !dres_out.hit)
    else $error("hit without request");
  a_src_idle: assert property (!src_valid_in |=> !src_drop_out)
    else $error("source drop without probe");
endmodule : sat_monitor
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sat_pkg::*;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] v;
  sat_lookup_req_t dreq = '0;
  sat_lookup_res_t hres = '0;
  sat_lookup_res_t dres;
  logic ustg = 1'b0;
  logic hstat = 1'b0;
  logic sv = 1'b0;
  logic [47:0] smac = 48'h0;
  logic sdrop;
  logic busy;
  int bad_count = 0;
  int n_checks = 0;
  // Slot 0 invalid, slot 3 full featured, slot 15 source drop
  localparam sat_entry_t E0 = {32'h0, 32'h2, 32'h0, 32'h2};
  localparam sat_entry_t E3 = {32'hb400_0002, 32'hc000_002f, 32'h0011_1234, 32'h5678_9abc};
  localparam sat_entry_t EF = {32'hc000_0000, 32'h1, 32'h0000_aaaa, 32'h1};
  localparam sat_entry_t ONES = {32'hfc00_0007, 32'hc000_006f, 32'h007f_ffff, 32'hffff_ffff};
  localparam logic [47:0] M3 = 48'h1234_5678_9abc;
  always #2.5 mclk_in = ~mclk_in;
  sat_top u_sat_top (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .dreq_in(dreq), .use_stg_in(ustg), .hres_in(hres), .hres_static_in(hstat),
    .dres_out(dres), .src_valid_in(sv), .src_mac_in(smac), .src_drop_out(sdrop),
    .busy_out(busy));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic cmd(input logic [3:0] s, input logic dir, input logic ts, input logic junk);
    int n;
    wr_reg(SAT_OFS_CTRL, {24'h0, 2'b10, dir, ts, s});
    if (junk) wr_reg(SAT_OFS_WORD4, 32'hdead_beef);
    rd_reg(SAT_OFS_CTRL, v);
    if (!junk) chk("go_set", 32'h1, {31'h0, v[7]});
    if (!junk) chk("busy_set", 32'h1, {31'h0, busy});
    if (!junk) chk("ctrl_fields", {25'h0, 1'b0, dir, ts, s}, {25'h0, v[6:0]});
    for (n = 0; n < 20 && v[7] !== 1'b0; n++) rd_reg(SAT_OFS_CTRL, v);
    chk("go_clear", 32'h0, {31'h0, v[7]});
  endtask : cmd
  task automatic put(input logic [3:0] s, input logic ts, input sat_entry_t e);
    for (int i = 0; i < 4; i++) wr_reg(SAT_OFS_WORD1 + 12'(4 * i), e[127 - 32 * i -: 32]);
    cmd(s, 1'b0, ts, 1'b0);
  endtask : put
  task automatic get(input logic [3:0] s, input logic junk, input sat_entry_t e);
    cmd(s, 1'b1, 1'b0, junk);
    for (int i = 0; i < 4; i++) begin
      rd_reg(SAT_OFS_WORD1 + 12'(4 * i), v);
      chk("entry_word", e[127 - 32 * i -: 32], v);
    end
  endtask : get
  task automatic look(input logic [47:0] m, input logic [6:0] f, input logic [2:0] g,
                      input logic mc, input logic [2:0] md, input logic [7:0] e);
    @(posedge mclk_in);
    dreq <= '{1'b1, m, f, g, mc};
    hres <= '{md[1], 1'b0, 1'b0, 3'h0, 7'h40};
    hstat <= md[0];
    ustg <= md[2];
    @(posedge mclk_in);
    dreq.valid <= 1'b0;
    hres.hit <= 1'b0;
    #1 chk("dest_hit_ports", {24'h0, e}, {24'h0, {dres.hit, dres.ports} & (e[7] ? 8'hff : 8'h80)});
  endtask : look
  task automatic src(input logic [47:0] m, input logic e);
    @(posedge mclk_in);
    sv <= 1'b1;
    smac <= m;
    @(posedge mclk_in);
    sv <= 1'b0;
    #1 chk("src_drop", {31'h0, e}, {31'h0, sdrop});
  endtask : src
  task automatic conclude();
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd_reg(SAT_OFS_WORD1 + 12'(4 * i), v);
      chk("word_reset", 32'h0, v);
    end
    rd_reg(12'h000, v);
    chk("unmapped", 32'h0, v);
    for (int i = 0; i < 4; i++) begin
      wr_reg(SAT_OFS_WORD1 + 12'(4 * i), 32'hffff_ffff);
      rd_reg(SAT_OFS_WORD1 + 12'(4 * i), v);
      chk("word_mask", ONES[127 - 32 * i -: 32], v);
    end
    put(4'd3, 1'b0, E3);
    put(4'd15, 1'b0, EF);
    put(4'd0, 1'b0, E0);
    get(4'd3, 1'b0, E3);
    put(4'd3, 1'b1, EF);
    // Other table code must leave the data words untouched
    cmd(4'd3, 1'b1, 1'b1, 1'b0);
    rd_reg(SAT_OFS_WORD1, v);
    chk("tsel_read", EF[127:96], v);
    get(4'd3, 1'b0, E3);
    get(4'd15, 1'b1, EF);
    look(M3, 7'h11, 3'h2, 1'b1, 3'b000, 8'haf);
    chk("dest_attr", 32'h1d, {27'h0, dres.drop, dres.bypass, dres.prio});
    look(M3, 7'h12, 3'h2, 1'b1, 3'b000, 8'h00);
    look(M3, 7'h12, 3'h2, 1'b0, 3'b000, 8'haf);
    look(M3, 7'h11, 3'h3, 1'b0, 3'b100, 8'h00);
    look(M3, 7'h11, 3'h2, 1'b0, 3'b100, 8'haf);
    look(48'h2, 7'h0, 3'h0, 1'b0, 3'b000, 8'h00);
    look(M3, 7'h11, 3'h2, 1'b0, 3'b010, 8'haf);
    look(M3, 7'h11, 3'h2, 1'b0, 3'b011, 8'hc0);
    look(48'haaaa_0000_0001, 7'h0, 3'h0, 1'b0, 3'b000, 8'h81);
    src(48'haaaa_0000_0001, 1'b1);
    src(M3, 1'b0);
    repeat (300) @(posedge mclk_in);
    look(M3, 7'h11, 3'h2, 1'b0, 3'b000, 8'haf);
    conclude();
  end
  // Whole run is near 464 cycles
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
endmodule : tb
bind sat_top sat_monitor #(.ENTRIES(ENTRIES)) u_sat_monitor (.mclk_in(mclk_in),
  .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .dreq_in(dreq_in), .use_stg_in(use_stg_in), .hres_in(hres_in),
  .hres_static_in(hres_static_in), .dres_out(dres_out), .src_valid_in(src_valid_in),
  .src_mac_in(src_mac_in), .src_drop_out(src_drop_out), .busy_out(busy_out));
`default_nettype wire

// ===== verilog/sat_lookup.sv
`timescale 1ns/1ps
`default_nettype none
// Searches all entries in parallel and folds in the hashed-table result
module sat_lookup
  import sat_pkg::*;
#(
  parameter int ENTRIES = SAT_ENTRIES
) (
  // Table contents
  input wire sat_entry_t table_in [ENTRIES],
  // Destination request
  input wire sat_lookup_req_t dreq_in,
  input wire logic use_stg_in,
  // Hashed-table result
  input wire sat_lookup_res_t hres_in,
  input wire logic hres_static_in,
  // Source learning
  input wire logic src_valid_in,
  input wire logic [47:0] src_mac_in,
  // Results
  output sat_lookup_res_t dres_out,
  output logic src_drop_out
);
  sat_lookup_res_t sres;
  logic smatch;

  always_comb begin
    sres = '0;
    src_drop_out = 1'b0;
    smatch = 1'b0;
    // Highest index wins among several hits
    for (int i = 0; i < ENTRIES; i++) begin
      if (dreq_in.valid && sat_entry_match(table_in[i], dreq_in.mac, dreq_in.filter_group_id,
                                           dreq_in.stg, dreq_in.mcast, use_stg_in)) begin
        sres.hit = 1'b1;
        sres.drop = table_in[i].w1[SAT_W1_DDROP_BIT];
        sres.bypass = table_in[i].w2[SAT_W2_BYP_BIT];
        sres.prio = table_in[i].w1[SAT_W1_PRIO_LSB +: 3];
        sres.ports = table_in[i].w2[SAT_W2_MASK_LSB +: 7];
      end
      smatch = table_in[i].w1[SAT_W1_VALID_BIT] &&
               ({table_in[i].w3[15:0], table_in[i].w4} == src_mac_in);
      if (src_valid_in && smatch && table_in[i].w1[SAT_W1_SDROP_BIT]) begin
        src_drop_out = 1'b1;
      end
    end
    // Static hits beat a dynamic hashed hit
    if (sres.hit && !(hres_in.hit && hres_static_in)) begin
      dres_out = sres;
    end else if (hres_in.hit && hres_static_in) begin
      dres_out = hres_in;
    end else begin
      dres_out = sres.hit ? sres : hres_in;
    end
  end
endmodule : sat_lookup
`default_nettype wire

// ===== verilog/sat_pkg.sv
`default_nettype none
package sat_pkg;
  // Register byte addresses
  localparam logic [11:0] SAT_OFS_WORD1 = 12'h420;
  localparam logic [11:0] SAT_OFS_WORD2 = 12'h424;
  localparam logic [11:0] SAT_OFS_WORD3 = 12'h428;
  localparam logic [11:0] SAT_OFS_WORD4 = 12'h42c;
  localparam logic [11:0] SAT_OFS_CTRL = 12'h41c;
  // Control register fields
  localparam int SAT_CTRL_GO_BIT = 7;
  localparam int SAT_CTRL_DIR_BIT = 5;
  localparam int SAT_CTRL_TSEL_BIT = 4;
  localparam int SAT_CTRL_SLOT_LSB = 0;
  localparam int SAT_SLOT_W = 4;
  localparam int SAT_ENTRIES = 16;
  // Word 1 fields
  localparam int SAT_W1_VALID_BIT = 31;
  localparam int SAT_W1_SDROP_BIT = 30;
  localparam int SAT_W1_DDROP_BIT = 29;
  localparam int SAT_W1_PRIO_LSB = 26;
  localparam int SAT_W1_STG_LSB = 0;
  // Word 2 fields
  localparam int SAT_W2_BYP_BIT = 31;
  localparam int SAT_W2_FIDM_BIT = 30;
  localparam int SAT_W2_MASK_LSB = 0;
  // Word 3 fields
  localparam int SAT_W3_FID_LSB = 16;
  localparam int SAT_W3_MACH_LSB = 0;
  // Write masks: reserved bits read as zero
  localparam logic [31:0] SAT_W1_MASK = 32'hfc00_0007;
  localparam logic [31:0] SAT_W2_MASK = 32'hc000_006f;
  localparam logic [31:0] SAT_W3_MASK = 32'h007f_ffff;
  localparam logic [31:0] SAT_W4_MASK = 32'hffff_ffff;
  localparam logic [31:0] SAT_WORD_RST = 32'h0000_0000;
  // Cycles a table operation stays in SAT_BUSY; the go bit (busy_out) stays set one cycle longer
  localparam logic [1:0] SAT_OP_CYCLES = 2'h2;

  typedef struct packed {
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    logic [31:0] w4;
  } sat_entry_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sat_bus_req_t;

  typedef struct packed {
    logic valid;
    logic [47:0] mac;
    logic [6:0] filter_group_id;
    logic [2:0] stg;
    logic mcast;
  } sat_lookup_req_t;

  typedef struct packed {
    logic hit;
    logic drop;
    logic bypass;
    logic [2:0] prio;
    logic [6:0] ports;
  } sat_lookup_res_t;

  typedef enum logic [2:0] {
    SAT_IDLE = 3'b001,
    SAT_BUSY = 3'b010,
    SAT_DONE = 3'b100
  } sat_state_t;

  function automatic logic sat_entry_match(input sat_entry_t e, input logic [47:0] mac,
                                           input logic [6:0] filter_group_id, input logic [2:0] stg,
                                           input logic mcast, input logic use_stg);
    logic fid_ok;
    fid_ok = !(mcast && e.w2[SAT_W2_FIDM_BIT]) || (e.w3[SAT_W3_FID_LSB +: 7] == filter_group_id);
    sat_entry_match = e.w1[SAT_W1_VALID_BIT] && ({e.w3[15:0], e.w4} == mac) && fid_ok &&
                      (!use_stg || (e.w1[SAT_W1_STG_LSB +: 3] == stg));
  endfunction : sat_entry_match
endpackage : sat_pkg
`default_nettype wire

// ===== verilog/sat_store.sv
`timescale 1ns/1ps
`default_nettype none
// Entry storage; written only by host commands, never aged
module sat_store
  import sat_pkg::*;
#(
  parameter int ENTRIES = SAT_ENTRIES
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Write port
  input wire logic wr_in,
  input wire logic [SAT_SLOT_W-1:0] wr_slot_in,
  input wire sat_entry_t wr_entry_in,
  // Whole table
  output sat_entry_t table_out [ENTRIES]
);
  typedef struct packed {
    sat_entry_t [ENTRIES-1:0] e;
  } sat_store_st_t;
  sat_store_st_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (wr_in) begin
      st_d.e[wr_slot_in] = wr_entry_in;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  always_comb begin
    for (int i = 0; i < ENTRIES; i++) begin
      table_out[i] = st_q.e[i];
    end
  end
endmodule : sat_store
`default_nettype wire

// ===== verilog/sat_top.sv
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Sixteen static entries, written only by software commands, never learned.
// - Static entries are never aged out or invalidated.
// - Every destination lookup searches the static table with the other tables.
// - Static hits, either table, outrank dynamic lookup results.
// - Table chooser zero selects the static table.
// - Go bit clears itself when the operation completes.
// - Finished read with table chooser zero places the entry into the four data words.
// - Word 1 bit 31 marks entry in use; unused never matches.
// - Word 1 bit 30 drops packets whose source matches.
// - Word 1 bit 29 drops packets whose destination matches.
// - Word 1 priority 28:26, group 2:0; other bits read zero.
// - Word 2 bit 31 lets matching packets bypass port state.
// - Word 2 bit 30 adds filter group compare for multicast.
// - Word 3 filter group in 22:16; 31:23 read zero.
// - MAC bits 47:32 in word 3 15:0, bits 31:0 in word 4.
module sat_top
  import sat_pkg::*;
#(
  parameter int ENTRIES = SAT_ENTRIES
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Register port
  input wire logic [11:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Destination lookup
  input wire sat_lookup_req_t dreq_in,
  input wire logic use_stg_in,
  input wire sat_lookup_res_t hres_in,
  input wire logic hres_static_in,
  output sat_lookup_res_t dres_out,
  // Source learning
  input wire logic src_valid_in,
  input wire logic [47:0] src_mac_in,
  output logic src_drop_out,
  // Status
  output logic busy_out
);
  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    sat_state_t state;
    sat_entry_t words;
    logic [SAT_SLOT_W-1:0] slot;
    logic dir;
    logic tsel;
    logic go;
    logic [1:0] cnt;
    logic [31:0] rdata;
    sat_lookup_res_t dres;
    logic sdrop;
  } sat_top_st_t;

  sat_top_st_t st_q, st_d;
  sat_entry_t table_w [ENTRIES];
  sat_lookup_res_t dres_w;
  logic sdrop_w;
  logic store_wr;
  logic ctrl_wr;

  function automatic logic [31:0] sat_mask_word(input logic [11:0] a, input logic [31:0] d);
    case (a)
      SAT_OFS_WORD1: sat_mask_word = d & SAT_W1_MASK;
      SAT_OFS_WORD2: sat_mask_word = d & SAT_W2_MASK;
      SAT_OFS_WORD3: sat_mask_word = d & SAT_W3_MASK;
      SAT_OFS_WORD4: sat_mask_word = d & SAT_W4_MASK;
      default: sat_mask_word = 32'h0000_0000;
    endcase
  endfunction : sat_mask_word

  ////////////////////////////////////////////////////////////////////////////////
  sat_store #(
    .ENTRIES(ENTRIES)
  ) u_store (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .wr_in(store_wr),
    .wr_slot_in(st_q.slot),
    .wr_entry_in(st_q.words),
    .table_out(table_w)
  );

  sat_lookup #(
    .ENTRIES(ENTRIES)
  ) u_lookup (
    .table_in(table_w),
    .dreq_in(dreq_in),
    .use_stg_in(use_stg_in),
    .hres_in(hres_in),
    .hres_static_in(hres_static_in),
    .src_valid_in(src_valid_in),
    .src_mac_in(src_mac_in),
    .dres_out(dres_w),
    .src_drop_out(sdrop_w)
  );

  // Only a static-table write reaches storage; other table codes are not here
  assign store_wr = (st_q.state == SAT_DONE) && !st_q.dir && !st_q.tsel;
  assign ctrl_wr = reg_wr_in && (reg_addr_in == SAT_OFS_CTRL);

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    st_d.dres = dres_w;
    st_d.sdrop = sdrop_w;
    st_d.rdata = 32'h0000_0000;
    // Data words are software writable only while idle
    if (reg_wr_in && !st_q.go) begin
      case (reg_addr_in)
        SAT_OFS_WORD1: st_d.words.w1 = sat_mask_word(reg_addr_in, reg_wdata_in);
        SAT_OFS_WORD2: st_d.words.w2 = sat_mask_word(reg_addr_in, reg_wdata_in);
        SAT_OFS_WORD3: st_d.words.w3 = sat_mask_word(reg_addr_in, reg_wdata_in);
        SAT_OFS_WORD4: st_d.words.w4 = sat_mask_word(reg_addr_in, reg_wdata_in);
        default: ;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        SAT_OFS_WORD1: st_d.rdata = st_q.words.w1;
        SAT_OFS_WORD2: st_d.rdata = st_q.words.w2;
        SAT_OFS_WORD3: st_d.rdata = st_q.words.w3;
        SAT_OFS_WORD4: st_d.rdata = st_q.words.w4;
        SAT_OFS_CTRL: st_d.rdata = {24'h000000, st_q.go, 1'b0, st_q.dir, st_q.tsel,
                                    st_q.slot};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
    case (st_q.state)
      SAT_IDLE: begin
        if (ctrl_wr) begin
          st_d.slot = reg_wdata_in[SAT_CTRL_SLOT_LSB +: SAT_SLOT_W];
          st_d.tsel = reg_wdata_in[SAT_CTRL_TSEL_BIT];
          st_d.dir = reg_wdata_in[SAT_CTRL_DIR_BIT];
          if (reg_wdata_in[SAT_CTRL_GO_BIT]) begin
            st_d.go = 1'b1;
            st_d.cnt = SAT_OP_CYCLES;
            st_d.state = SAT_BUSY;
          end
        end
      end
      SAT_BUSY: begin
        // Command writes land here and are dropped
        st_d.cnt = st_q.cnt - 2'h1;
        if (st_q.cnt == 2'h1) begin
          st_d.state = SAT_DONE;
        end
      end
      SAT_DONE: begin
        if (st_q.dir && !st_q.tsel) begin
          st_d.words = table_w[st_q.slot];
        end
        st_d.go = 1'b0;
        st_d.state = SAT_IDLE;
      end
      default: begin
        st_d.state = SAT_IDLE;
        st_d.go = 1'b0;
      end
    endcase
  end

  // No aging path exists into storage, so entries persist
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= '0;
      st_q.state <= SAT_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign reg_rdata_out = st_q.rdata;
  assign dres_out = st_q.dres;
  assign src_drop_out = st_q.sdrop;
  assign busy_out = st_q.go;
endmodule : sat_top
`default_nettype wire
